// ==== common/psalu_pkg.sv ====
// Shared constants and types for the packed SIMD integer datapath.
package psalu_pkg;
   localparam int QW = 64;
   localparam int DW = 32;
   localparam int NREG = 8;
   localparam int RIDX_W = 3;
   localparam int WIDE_W = 128;
   localparam int FP_W = 80;
   localparam int CSR_W = 32;
   localparam int SLOT_W = 128;
   localparam int SLOT_IDX_W = 5;
   localparam logic [4:0] SLOT_FP_BASE = 5'h00;
   localparam logic [4:0] SLOT_SIMD_BASE = 5'h08;
   localparam logic [4:0] SLOT_WIDE_BASE = 5'h10;
   localparam logic [4:0] SLOT_CSR = 5'h18;
   localparam logic [63:0] SIMD_RST = 64'h0;
   localparam logic [31:0] CSR_RST = 32'h0;
   localparam int BYTE_W = 8;
   localparam int WORD_W = 16;
   localparam int DWORD_W = 32;

   typedef enum logic [5:0] {
      nop_op, move_dword_op, move_qword_op,
      pack_word_to_byte_signed_sat, pack_dword_to_word_signed_sat,
      pack_word_to_byte_unsigned_sat,
      interleave_high_bytes, interleave_high_words, interleave_high_dwords,
      interleave_low_bytes, interleave_low_words, interleave_low_dwords,
      lane_add_byte, lane_add_word, lane_add_dword,
      lane_add_byte_signed_sat, lane_add_word_signed_sat,
      lane_add_byte_unsigned_sat, lane_add_word_unsigned_sat,
      lane_sub_byte, lane_sub_word, lane_sub_dword,
      lane_sub_byte_signed_sat, lane_sub_word_signed_sat,
      lane_sub_byte_unsigned_sat, lane_sub_word_unsigned_sat,
      lane_mul_word_high, lane_mul_word_low, lane_mul_pair_accumulate,
      lane_cmp_eq_byte, lane_cmp_eq_word, lane_cmp_eq_dword,
      lane_cmp_gt_byte, lane_cmp_gt_word, lane_cmp_gt_dword,
      logic_and_op, logic_andn_op, logic_or_op, logic_xor_op,
      shift_left_word, shift_left_dword, shift_left_qword,
      shift_right_word_logical, shift_right_dword_logical, shift_right_qword_logical,
      shift_right_word_arith, shift_right_dword_arith,
      empty_simd_state_op, save_fp_simd_state_op, restore_fp_simd_state_op
   } psalu_op_t;

   typedef enum logic [1:0] {
      loc_simd, loc_mem, loc_gpr
   } psalu_loc_t;
endpackage : psalu_pkg

// ==== common/psalu_lane_if.sv ====
// Carrier between the datapath top and its lane arithmetic unit.
`timescale 1ns/1ps
`default_nettype none
interface psalu_lane_if;
   psalu_pkg::psalu_op_t op;
   logic [psalu_pkg::QW-1:0] a;
   logic [psalu_pkg::QW-1:0] b;
   logic [psalu_pkg::QW-1:0] y;
   modport req (output op, output a, output b, input y);
   modport alu (input op, input a, input b, output y);
endinterface : psalu_lane_if
`default_nettype wire

// ==== verilog/psalu_lane_arith.sv ====
// Combinational lane add, subtract, multiply and compare unit.
`timescale 1ns/1ps
`default_nettype none
module psalu_lane_arith (
   psalu_lane_if.alu lane
);
   // Lanes up to 32 bits wide, held in 34-bit signed space so sums never overflow.
   function automatic logic [63:0] lanes_as(input logic [63:0] a, input logic [63:0] b,
         input int w, input logic sub, input logic sat, input logic sgn);
      logic [63:0] m;
      logic [63:0] y;
      logic signed [33:0] x;
      logic signed [33:0] z;
      logic signed [33:0] r;
      logic signed [33:0] hi;
      logic signed [33:0] lo;
      m = (64'h1 << w) - 64'h1;
      y = '0;
      for (int i = 0; i < 8; i++) begin
         if (i * w < 64) begin
            x = 34'((a >> (i * w)) & m);
            z = 34'((b >> (i * w)) & m);
            if (sgn && x[w-1]) x = x | ~34'(m);
            if (sgn && z[w-1]) z = z | ~34'(m);
            r = sub ? x - z : x + z;
            if (sat) begin
               hi = sgn ? 34'(m >> 1) : 34'(m);
               lo = sgn ? -34'(m >> 1) - 34'sd1 : 34'sd0;
               if (r > hi) r = hi;
               if (r < lo) r = lo;
            end
            y = y | ((64'(r) & m) << (i * w));
         end
      end
      return y;
   endfunction : lanes_as

   function automatic logic [63:0] lanes_cmp(input logic [63:0] a, input logic [63:0] b,
         input int w, input logic gt);
      logic [63:0] m;
      logic [63:0] y;
      logic signed [33:0] x;
      logic signed [33:0] z;
      logic hit;
      m = (64'h1 << w) - 64'h1;
      y = '0;
      for (int i = 0; i < 8; i++) begin
         if (i * w < 64) begin
            x = 34'((a >> (i * w)) & m);
            z = 34'((b >> (i * w)) & m);
            if (x[w-1]) x = x | ~34'(m);
            if (z[w-1]) z = z | ~34'(m);
            hit = gt ? (x > z) : (x == z);
            if (hit) y = y | (m << (i * w));
         end
      end
      return y;
   endfunction : lanes_cmp

   logic signed [31:0] prod [4];
   logic [63:0] mul_hi;
   logic [63:0] mul_lo;
   logic [63:0] mul_acc;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         prod[i] = $signed(lane.a[i*16 +: 16]) * $signed(lane.b[i*16 +: 16]);
         mul_hi[i*16 +: 16] = prod[i][31:16];
         mul_lo[i*16 +: 16] = prod[i][15:0];
      end
      for (int j = 0; j < 2; j++) begin
         mul_acc[j*32 +: 32] = 32'(prod[2*j] + prod[2*j+1]);
      end
   end

   always_comb begin
      case (lane.op)
         // Plain lanes wrap; carries never cross into the next lane.
         psalu_pkg::lane_add_byte: lane.y = lanes_as(lane.a, lane.b, psalu_pkg::BYTE_W, 1'b0, 1'b0, 1'b0);
         psalu_pkg::lane_add_word: lane.y = lanes_as(lane.a, lane.b, psalu_pkg::WORD_W, 1'b0, 1'b0, 1'b0);
         psalu_pkg::lane_add_dword: lane.y = lanes_as(lane.a, lane.b, psalu_pkg::DWORD_W, 1'b0, 1'b0, 1'b0);
         psalu_pkg::lane_add_byte_signed_sat: lane.y = lanes_as(lane.a, lane.b, psalu_pkg::BYTE_W, 1'b0, 1'b1, 1'b1);
         psalu_pkg::lane_add_word_signed_sat: lane.y = lanes_as(lane.a, lane.b, psalu_pkg::WORD_W, 1'b0, 1'b1, 1'b1);
         psalu_pkg::lane_add_byte_unsigned_sat: lane.y = lanes_as(lane.a, lane.b, psalu_pkg::BYTE_W, 1'b0, 1'b1, 1'b0);
         psalu_pkg::lane_add_word_unsigned_sat: lane.y = lanes_as(lane.a, lane.b, psalu_pkg::WORD_W, 1'b0, 1'b1, 1'b0);
         psalu_pkg::lane_sub_byte: lane.y = lanes_as(lane.a, lane.b, psalu_pkg::BYTE_W, 1'b1, 1'b0, 1'b0);
         psalu_pkg::lane_sub_word: lane.y = lanes_as(lane.a, lane.b, psalu_pkg::WORD_W, 1'b1, 1'b0, 1'b0);
         psalu_pkg::lane_sub_dword: lane.y = lanes_as(lane.a, lane.b, psalu_pkg::DWORD_W, 1'b1, 1'b0, 1'b0);
         psalu_pkg::lane_sub_byte_signed_sat: lane.y = lanes_as(lane.a, lane.b, psalu_pkg::BYTE_W, 1'b1, 1'b1, 1'b1);
         psalu_pkg::lane_sub_word_signed_sat: lane.y = lanes_as(lane.a, lane.b, psalu_pkg::WORD_W, 1'b1, 1'b1, 1'b1);
         psalu_pkg::lane_sub_byte_unsigned_sat: lane.y = lanes_as(lane.a, lane.b, psalu_pkg::BYTE_W, 1'b1, 1'b1, 1'b0);
         psalu_pkg::lane_sub_word_unsigned_sat: lane.y = lanes_as(lane.a, lane.b, psalu_pkg::WORD_W, 1'b1, 1'b1, 1'b0);
         psalu_pkg::lane_mul_word_high: lane.y = mul_hi;
         psalu_pkg::lane_mul_word_low: lane.y = mul_lo;
         psalu_pkg::lane_mul_pair_accumulate: lane.y = mul_acc;
         psalu_pkg::lane_cmp_eq_byte: lane.y = lanes_cmp(lane.a, lane.b, psalu_pkg::BYTE_W, 1'b0);
         psalu_pkg::lane_cmp_eq_word: lane.y = lanes_cmp(lane.a, lane.b, psalu_pkg::WORD_W, 1'b0);
         psalu_pkg::lane_cmp_eq_dword: lane.y = lanes_cmp(lane.a, lane.b, psalu_pkg::DWORD_W, 1'b0);
         psalu_pkg::lane_cmp_gt_byte: lane.y = lanes_cmp(lane.a, lane.b, psalu_pkg::BYTE_W, 1'b1);
         psalu_pkg::lane_cmp_gt_word: lane.y = lanes_cmp(lane.a, lane.b, psalu_pkg::WORD_W, 1'b1);
         psalu_pkg::lane_cmp_gt_dword: lane.y = lanes_cmp(lane.a, lane.b, psalu_pkg::DWORD_W, 1'b1);
         default: lane.y = '0;
      endcase
   end
endmodule : psalu_lane_arith
`default_nettype wire

// ==== verilog/psalu_top.sv ====
// Packed SIMD integer datapath with SIMD register file and state save/restore.
// Operation
// - Move doubleword or quadword between SIMD registers and memory.
// - Source operand comes from memory, a SIMD register or a general register.
// - Signed pack narrows words or dwords, clamping to narrower signed limits.
// - Unsigned pack narrows signed words to bytes clamped to 0..255.
// - Unpack interleaves high or low halves of byte, word or dword lanes.
// - Plain add sums byte, word or dword lanes independently.
// - Signed-saturating add clamps byte or word lanes to signed limits.
// - Unsigned-saturating add clamps byte or word lanes to unsigned maximum.
// - Subtract in plain, signed-saturating and unsigned-saturating forms.
// - Multiply-high keeps upper 16 bits of each signed word product.
// - Multiply-low keeps lower 16 bits of each signed word product.
// - Multiply-accumulate sums adjacent pairs of word products into dwords.
// - Equality compare gives an all-ones or zero mask per lane.
// - Signed greater-than compare gives a per-lane mask.
// - Bitwise AND, AND-NOT, OR and XOR over the whole quadword.
// - Shifts act on word, dword or quadword lanes independently.
// - Logical shifts fill vacated bits with zeros.
// - Arithmetic right shifts of words or dwords fill with the sign bit.
// - Empty-state clears the SIMD registers.
// - Save and restore move FP stack, SIMD, wide registers and control word.
`timescale 1ns/1ps
`default_nettype none
module psalu_top (
   input wire logic i_clk_sys,
   input wire logic i_srst,
   input wire logic i_op_valid,
   input wire psalu_pkg::psalu_op_t i_op,
   input wire psalu_pkg::psalu_loc_t i_src_loc,
   input wire psalu_pkg::psalu_loc_t i_dst_loc,
   input wire logic [psalu_pkg::RIDX_W-1:0] i_src_reg,
   input wire logic [psalu_pkg::RIDX_W-1:0] i_dst_reg,
   input wire logic [psalu_pkg::QW-1:0] i_mem_rdata,
   input wire logic [psalu_pkg::DW-1:0] i_gpr_rdata,
   input wire logic i_restore_valid,
   input wire logic [psalu_pkg::SLOT_W-1:0] i_restore_data,
   output logic o_ready,
   output logic o_restore_ready,
   output logic o_done_ff,
   output logic [psalu_pkg::QW-1:0] o_result_ff,
   output logic o_mem_wvalid_ff,
   output logic [psalu_pkg::QW-1:0] o_mem_wdata_ff,
   output logic o_gpr_wvalid_ff,
   output logic [psalu_pkg::DW-1:0] o_gpr_wdata_ff,
   output logic o_save_valid_ff,
   output logic [psalu_pkg::SLOT_IDX_W-1:0] o_save_slot_ff,
   output logic [psalu_pkg::SLOT_W-1:0] o_save_data_ff,
   output logic [psalu_pkg::SLOT_IDX_W-1:0] o_restore_slot
);
   typedef enum logic [1:0] {
      st_idle, st_save, st_restore
   } psalu_state_t;

   // Narrow each source lane of width w to w/2 with signed or unsigned clamping.
   function automatic logic [63:0] lanes_pack(input logic [63:0] a, input logic [63:0] b,
         input int w, input logic uns);
      logic [63:0] y;
      logic [63:0] src;
      logic signed [33:0] x;
      logic signed [33:0] hi;
      logic signed [33:0] lo;
      int n;
      int o;
      y = '0;
      n = 64 / w;
      o = w / 2;
      hi = uns ? (34'sd1 <<< o) - 34'sd1 : (34'sd1 <<< (o - 1)) - 34'sd1;
      lo = uns ? 34'sd0 : -(34'sd1 <<< (o - 1));
      for (int i = 0; i < 8; i++) begin
         if (i < 2 * n) begin
            src = (i < n) ? a : b;
            x = 34'((src >> ((i % n) * w)) & ((64'h1 << w) - 64'h1));
            if (x[w-1]) x = x | ~34'((64'h1 << w) - 64'h1);
            if (x > hi) x = hi;
            if (x < lo) x = lo;
            y = y | ((64'(x) & ((64'h1 << o) - 64'h1)) << (i * o));
         end
      end
      return y;
   endfunction : lanes_pack

   function automatic logic [63:0] lanes_interleave(input logic [63:0] a,
         input logic [63:0] b, input int w, input logic high);
      logic [63:0] y;
      logic [63:0] m;
      int half;
      int base;
      y = '0;
      m = (64'h1 << w) - 64'h1;
      half = 32 / w;
      base = high ? half : 0;
      for (int i = 0; i < 4; i++) begin
         if (i < half) begin
            y = y | (((a >> ((base + i) * w)) & m) << (2 * i * w));
            y = y | (((b >> ((base + i) * w)) & m) << ((2 * i + 1) * w));
         end
      end
      return y;
   endfunction : lanes_interleave

   function automatic logic [63:0] lanes_shift(input logic [63:0] a, input logic [63:0] cnt,
         input int w, input logic left, input logic arith);
      logic [63:0] y;
      logic [63:0] m;
      logic signed [63:0] x;
      y = '0;
      m = (w == 64) ? '1 : (64'h1 << w) - 64'h1;
      for (int i = 0; i < 4; i++) begin
         if (i * w < 64) begin
            x = (a >> (i * w)) & m;
            if (arith && x[w-1]) x = x | ~m;
            if (cnt > 64'(w - 1)) begin
               x = (arith && x[w-1]) ? '1 : '0;
            end else if (left) begin
               x = x << cnt[5:0];
            end else begin
               x = arith ? x >>> cnt[5:0] : x >> cnt[5:0];
            end
            y = y | ((x & m) << (i * w));
         end
      end
      return y;
   endfunction : lanes_shift

   logic [psalu_pkg::QW-1:0] simd_ff [psalu_pkg::NREG];
   logic [psalu_pkg::WIDE_W-1:0] wide_ff [psalu_pkg::NREG];
   logic [psalu_pkg::FP_W-1:0] fp_ff [psalu_pkg::NREG];
   logic [psalu_pkg::CSR_W-1:0] csr_ff;
   psalu_state_t state_ff;
   psalu_state_t nxt_state;
   logic [psalu_pkg::SLOT_IDX_W-1:0] slot_ff;
   logic [psalu_pkg::SLOT_IDX_W-1:0] nxt_slot;
   logic [psalu_pkg::QW-1:0] opa;
   logic [psalu_pkg::QW-1:0] opb;
   logic [psalu_pkg::QW-1:0] res;
   logic issue;
   logic [psalu_pkg::RIDX_W-1:0] sidx;
   logic [psalu_pkg::SLOT_W-1:0] save_word;
   psalu_lane_if lane ();

   psalu_lane_arith u_arith (
      .lane(lane.alu)
   );

   assign o_ready = (state_ff == st_idle);
   assign o_restore_ready = (state_ff == st_restore);
   assign o_restore_slot = slot_ff;
   assign issue = i_op_valid && o_ready;
   assign sidx = slot_ff[psalu_pkg::RIDX_W-1:0];

   always_comb begin
      opa = simd_ff[i_dst_reg];
      case (i_src_loc)
         psalu_pkg::loc_mem: opb = i_mem_rdata;
         psalu_pkg::loc_gpr: opb = {{(psalu_pkg::QW - psalu_pkg::DW){1'b0}}, i_gpr_rdata};
         default: opb = simd_ff[i_src_reg];
      endcase
      lane.op = i_op;
      lane.a = opa;
      lane.b = opb;
   end

   always_comb begin
      case (i_op)
         psalu_pkg::move_dword_op: res = {{(psalu_pkg::QW - psalu_pkg::DW){1'b0}}, opb[psalu_pkg::DW-1:0]};
         psalu_pkg::move_qword_op: res = opb;
         psalu_pkg::pack_word_to_byte_signed_sat: res = lanes_pack(opa, opb, psalu_pkg::WORD_W, 1'b0);
         psalu_pkg::pack_dword_to_word_signed_sat: res = lanes_pack(opa, opb, psalu_pkg::DWORD_W, 1'b0);
         psalu_pkg::pack_word_to_byte_unsigned_sat: res = lanes_pack(opa, opb, psalu_pkg::WORD_W, 1'b1);
         psalu_pkg::interleave_high_bytes: res = lanes_interleave(opa, opb, psalu_pkg::BYTE_W, 1'b1);
         psalu_pkg::interleave_high_words: res = lanes_interleave(opa, opb, psalu_pkg::WORD_W, 1'b1);
         psalu_pkg::interleave_high_dwords: res = lanes_interleave(opa, opb, psalu_pkg::DWORD_W, 1'b1);
         psalu_pkg::interleave_low_bytes: res = lanes_interleave(opa, opb, psalu_pkg::BYTE_W, 1'b0);
         psalu_pkg::interleave_low_words: res = lanes_interleave(opa, opb, psalu_pkg::WORD_W, 1'b0);
         psalu_pkg::interleave_low_dwords: res = lanes_interleave(opa, opb, psalu_pkg::DWORD_W, 1'b0);
         psalu_pkg::logic_and_op: res = opa & opb;
         psalu_pkg::logic_andn_op: res = ~opa & opb;
         psalu_pkg::logic_or_op: res = opa | opb;
         psalu_pkg::logic_xor_op: res = opa ^ opb;
         psalu_pkg::shift_left_word: res = lanes_shift(opa, opb, psalu_pkg::WORD_W, 1'b1, 1'b0);
         psalu_pkg::shift_left_dword: res = lanes_shift(opa, opb, psalu_pkg::DWORD_W, 1'b1, 1'b0);
         psalu_pkg::shift_left_qword: res = lanes_shift(opa, opb, psalu_pkg::QW, 1'b1, 1'b0);
         psalu_pkg::shift_right_word_logical: res = lanes_shift(opa, opb, psalu_pkg::WORD_W, 1'b0, 1'b0);
         psalu_pkg::shift_right_dword_logical: res = lanes_shift(opa, opb, psalu_pkg::DWORD_W, 1'b0, 1'b0);
         psalu_pkg::shift_right_qword_logical: res = lanes_shift(opa, opb, psalu_pkg::QW, 1'b0, 1'b0);
         psalu_pkg::shift_right_word_arith: res = lanes_shift(opa, opb, psalu_pkg::WORD_W, 1'b0, 1'b1);
         psalu_pkg::shift_right_dword_arith: res = lanes_shift(opa, opb, psalu_pkg::DWORD_W, 1'b0, 1'b1);
         default: res = lane.y;
      endcase
   end

   // Save and restore walk the same slot order: FP stack, SIMD, wide, control word.
   always_comb begin
      nxt_state = state_ff;
      nxt_slot = slot_ff;
      case (state_ff)
         st_idle: begin
            nxt_slot = '0;
            if (issue && i_op == psalu_pkg::save_fp_simd_state_op) nxt_state = st_save;
            if (issue && i_op == psalu_pkg::restore_fp_simd_state_op) nxt_state = st_restore;
         end
         st_save: begin
            nxt_slot = slot_ff + 5'h01;
            if (slot_ff == psalu_pkg::SLOT_CSR) nxt_state = st_idle;
         end
         st_restore: begin
            if (i_restore_valid) begin
               nxt_slot = slot_ff + 5'h01;
               if (slot_ff == psalu_pkg::SLOT_CSR) nxt_state = st_idle;
            end
         end
         default: nxt_state = st_idle;
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         state_ff <= st_idle;
         slot_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         slot_ff <= nxt_slot;
      end
   end

   always_comb begin
      if (slot_ff < psalu_pkg::SLOT_SIMD_BASE) begin
         save_word = psalu_pkg::SLOT_W'(fp_ff[sidx]);
      end else if (slot_ff < psalu_pkg::SLOT_WIDE_BASE) begin
         save_word = psalu_pkg::SLOT_W'(simd_ff[sidx]);
      end else if (slot_ff < psalu_pkg::SLOT_CSR) begin
         save_word = wide_ff[sidx];
      end else begin
         save_word = psalu_pkg::SLOT_W'(csr_ff);
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         for (int r = 0; r < psalu_pkg::NREG; r++) simd_ff[r] <= psalu_pkg::SIMD_RST;
      end else if (issue && i_op == psalu_pkg::empty_simd_state_op) begin
         // Zeroing is the cheapest visible form of the empty state here.
         for (int r = 0; r < psalu_pkg::NREG; r++) simd_ff[r] <= psalu_pkg::SIMD_RST;
      end else if (state_ff == st_restore && i_restore_valid &&
                   slot_ff >= psalu_pkg::SLOT_SIMD_BASE && slot_ff < psalu_pkg::SLOT_WIDE_BASE) begin
         simd_ff[sidx] <= i_restore_data[psalu_pkg::QW-1:0];
      end else if (issue && i_dst_loc == psalu_pkg::loc_simd && i_op != psalu_pkg::nop_op &&
                   i_op != psalu_pkg::save_fp_simd_state_op &&
                   i_op != psalu_pkg::restore_fp_simd_state_op) begin
         simd_ff[i_dst_reg] <= res;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         for (int r = 0; r < psalu_pkg::NREG; r++) begin
            wide_ff[r] <= '0;
            fp_ff[r] <= '0;
         end
         csr_ff <= psalu_pkg::CSR_RST;
      end else if (state_ff == st_restore && i_restore_valid) begin
         if (slot_ff < psalu_pkg::SLOT_SIMD_BASE) begin
            fp_ff[sidx] <= i_restore_data[psalu_pkg::FP_W-1:0];
         end else if (slot_ff >= psalu_pkg::SLOT_WIDE_BASE && slot_ff < psalu_pkg::SLOT_CSR) begin
            wide_ff[sidx] <= i_restore_data;
         end else if (slot_ff == psalu_pkg::SLOT_CSR) begin
            csr_ff <= i_restore_data[psalu_pkg::CSR_W-1:0];
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_save_valid_ff <= 1'b0;
         o_save_slot_ff <= '0;
         o_save_data_ff <= '0;
      end else begin
         o_save_valid_ff <= (state_ff == st_save);
         o_save_slot_ff <= slot_ff;
         o_save_data_ff <= save_word;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_done_ff <= 1'b0;
         o_result_ff <= '0;
         o_mem_wvalid_ff <= 1'b0;
         o_mem_wdata_ff <= '0;
         o_gpr_wvalid_ff <= 1'b0;
         o_gpr_wdata_ff <= '0;
      end else begin
         o_done_ff <= (issue && i_op != psalu_pkg::save_fp_simd_state_op &&
                       i_op != psalu_pkg::restore_fp_simd_state_op) ||
                      (state_ff != st_idle && nxt_state == st_idle);
         o_mem_wvalid_ff <= issue && i_dst_loc == psalu_pkg::loc_mem &&
                            (i_op == psalu_pkg::move_dword_op || i_op == psalu_pkg::move_qword_op);
         o_gpr_wvalid_ff <= issue && i_dst_loc == psalu_pkg::loc_gpr &&
                            i_op == psalu_pkg::move_dword_op;
         if (issue) begin
            o_result_ff <= res;
            o_mem_wdata_ff <= res;
            o_gpr_wdata_ff <= res[psalu_pkg::DW-1:0];
         end
      end
   end
endmodule : psalu_top
`default_nettype wire

// ==== tb/psalu_asserts.sv ====
// Handshake and slot sequencing checks on the SIMD datapath ports.
`timescale 1ns/1ps
`default_nettype none
module psalu_asserts (
   input wire logic i_clk_sys,
   input wire logic i_srst,
   input wire logic i_op_valid,
   input wire logic i_restore_valid,
   input wire logic o_ready,
   input wire logic o_restore_ready,
   input wire logic o_done_ff,
   input wire logic o_save_valid_ff,
   input wire logic [4:0] o_save_slot_ff,
   input wire logic [4:0] o_restore_slot
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_srst);
   sequence word_s;
      o_restore_ready && i_restore_valid;
   endsequence
   op_done_a: assert property (i_op_valid && o_ready |=> o_done_ff || !o_ready)
      else $error("op done");
   save_first_a: assert property ($rose(o_save_valid_ff) |->
      o_save_slot_ff == 5'h00 && !o_ready) else $error("save first");
   save_step_a: assert property (o_save_valid_ff && o_save_slot_ff < 5'h18 |=>
      o_save_valid_ff && o_save_slot_ff == $past(o_save_slot_ff) + 5'h01) else $error("save");
   save_end_a: assert property (o_save_valid_ff && o_save_slot_ff == 5'h18 |->
      o_done_ff && o_ready) else $error("save end");
   rest_first_a: assert property ($rose(o_restore_ready) |->
      o_restore_slot == 5'h00 && !o_ready) else $error("restore first");
   rest_step_a: assert property (word_s ##0 o_restore_slot < 5'h18 |=>
      o_restore_slot == $past(o_restore_slot) + 5'h01) else $error("restore");
   rest_end_a: assert property (word_s ##0 o_restore_slot == 5'h18 |=>
      o_done_ff && o_ready && !o_restore_ready) else $error("restore end");
   rest_hold_a: assert property (o_restore_ready && !i_restore_valid |=>
      o_restore_ready && $stable(o_restore_slot)) else $error("restore hold");
endmodule : psalu_asserts
bind psalu_top psalu_asserts u_chk (.*);
`default_nettype wire

// ==== tb/psalu_issue_model.sv ====
// Issue-side model that hands over restore words, with gaps when stalled.
`timescale 1ns/1ps
`default_nettype none
module psalu_issue_model (
   input wire logic i_clk_sys,
   input wire logic i_stall,
   input wire logic i_rdy,
   input wire logic [4:0] i_slot,
   output logic o_vld = 1'b0,
   output logic [127:0] o_data = 128'h0
);
   // Idle data is inverted so a stale word can never pass for a fresh one.
   always @(negedge i_clk_sys) begin
      o_vld <= i_rdy && !(i_stall && o_vld);
      o_data <= {16{i_rdy && !(i_stall && o_vld) ? {3'h0, i_slot} : ~{3'h0, i_slot}}};
   end
endmodule : psalu_issue_model
`default_nettype wire

// ==== tb/test_packed_simd_integer_alu.sv ====
// Self-checking bench for the packed SIMD integer datapath.
`timescale 1ns/1ps
`default_nettype none
module test_packed_simd_integer_alu;
   logic i_clk_sys = 1'b0, i_srst = 1'b1, i_op_valid = 1'b0, stall = 1'b0;
   psalu_pkg::psalu_op_t i_op = psalu_pkg::nop_op;
   psalu_pkg::psalu_loc_t i_src_loc = psalu_pkg::loc_mem, i_dst_loc = psalu_pkg::loc_simd;
   logic [2:0] i_src_reg = 3'h1, i_dst_reg = 3'h1;
   logic [63:0] i_mem_rdata = 64'h0, o_result_ff, o_mem_wdata_ff;
   logic [31:0] i_gpr_rdata = 32'hC0DE5A5A, o_gpr_wdata_ff;
   logic [127:0] i_restore_data, o_save_data_ff;
   logic [4:0] o_save_slot_ff, o_restore_slot;
   logic i_restore_valid, o_ready, o_restore_ready, o_done_ff, o_save_valid_ff;
   logic o_mem_wvalid_ff, o_gpr_wvalid_ff;
   int n_fail = 0, checks = 0, cyc = 0;
   psalu_top dut (.*);
   psalu_issue_model far (.i_clk_sys(i_clk_sys), .i_stall(stall), .i_rdy(o_restore_ready),
      .i_slot(o_restore_slot), .o_vld(i_restore_valid), .o_data(i_restore_data));
   initial forever #20 i_clk_sys = ~i_clk_sys;
   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 1500) begin
         n_fail++;
         end_sim();
      end
   end
   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic go(input psalu_pkg::psalu_op_t op, input logic [63:0] b);
      i_op = op;
      i_mem_rdata = b;
      i_op_valid = 1'b1;
      @(negedge i_clk_sys);
   endtask : go
   // Loading operand A and using it on the next edge also exercises back-to-back issue.
   task automatic ex(input psalu_pkg::psalu_op_t op, input logic [63:0] a, b, y);
      go(psalu_pkg::move_qword_op, a);
      go(op, b);
      i_op_valid = 1'b0;
      chk(128'(o_result_ff), 128'(y));
      @(negedge i_clk_sys);
   endtask : ex
   task automatic t_arith;
      ex(psalu_pkg::lane_add_byte, 64'hFF, 64'h01, 64'h00);
      ex(psalu_pkg::lane_add_byte_signed_sat, 64'h807F, 64'hFF01, 64'h807F);
      ex(psalu_pkg::lane_add_word_unsigned_sat, 64'hFFFF, 64'h01, 64'hFFFF);
      ex(psalu_pkg::lane_sub_word_signed_sat, 64'h8000, 64'h01, 64'h8000);
      $display("arith test over");
   endtask : t_arith
   task automatic t_lanes;
      ex(psalu_pkg::pack_word_to_byte_signed_sat, 64'h01008000, 64'h0, 64'h7F80);
      ex(psalu_pkg::pack_word_to_byte_unsigned_sat, 64'h01008000, 64'h0, 64'hFF00);
      ex(psalu_pkg::interleave_low_words, 64'h20001, 64'h40003, 64'h4000200030001);
      ex(psalu_pkg::lane_mul_word_high, 64'hFFFF4000, 64'h20004, 64'hFFFF0001);
      ex(psalu_pkg::lane_mul_pair_accumulate, 64'h30002, 64'h50004, 64'h17);
      ex(psalu_pkg::lane_cmp_eq_word, 64'h10002, 64'h10003, 64'hFFFFFFFFFFFF0000);
      ex(psalu_pkg::lane_cmp_gt_byte, 64'h8001, 64'h7FFF, 64'hFF);
      ex(psalu_pkg::logic_andn_op, 64'hF0F0, 64'hFFFF, 64'h0F0F);
      $display("lane test over");
   endtask : t_lanes
   task automatic t_shift;
      ex(psalu_pkg::shift_left_word, 64'h80010FFF, 64'h4, 64'h10FFF0);
      ex(psalu_pkg::shift_right_word_arith, 64'h80007FFF, 64'h10, 64'hFFFF0000);
      ex(psalu_pkg::shift_right_dword_logical, 64'h1080000000, 64'h4, 64'h108000000);
      ex(psalu_pkg::shift_left_qword, 64'h1, 64'h40, 64'h0);
      ex(psalu_pkg::shift_right_qword_logical, 64'h8000000000000000, 64'h3F, 64'h1);
      $display("shift test over");
   endtask : t_shift
   task automatic t_move;
      i_src_loc = psalu_pkg::loc_gpr;
      i_dst_loc = psalu_pkg::loc_mem;
      go(psalu_pkg::move_dword_op, 64'h0);
      i_dst_loc = psalu_pkg::loc_gpr;
      chk(128'({o_mem_wvalid_ff, o_mem_wdata_ff}), 128'h1_0000_0000_C0DE_5A5A);
      go(psalu_pkg::move_dword_op, 64'h0);
      i_op_valid = 1'b0;
      chk(128'({o_mem_wvalid_ff, o_gpr_wvalid_ff, o_gpr_wdata_ff}), 128'h1_C0DE_5A5A);
      i_src_loc = psalu_pkg::loc_mem;
      i_dst_loc = psalu_pkg::loc_simd;
      $display("move test over");
   endtask : t_move
   task automatic t_state;
      go(psalu_pkg::move_qword_op, 64'hA5);
      go(psalu_pkg::empty_simd_state_op, 64'h0);
      go(psalu_pkg::lane_add_byte, 64'h0);
      chk(128'(o_result_ff), 128'h0);
      stall = 1'b1;
      go(psalu_pkg::restore_fp_simd_state_op, 64'h0);
      i_op_valid = 1'b0;
      for (int i = 0; i < 99 && o_done_ff !== 1'b1; i++)
         @(negedge i_clk_sys);
      go(psalu_pkg::save_fp_simd_state_op, 64'h0);
      i_op_valid = 1'b0;
      for (int i = 0; i < 9 && o_save_valid_ff !== 1'b1; i++)
         @(negedge i_clk_sys);
      // Each slot comes back cut to the width of the register it holds.
      for (int s = 0; s < 25; s++) begin
         chk(o_save_data_ff, {16{3'h0, 5'(s)}} & ~({128{1'b1}} << (s < 8 ? 80 : s < 16 ? 64 :
            s < 24 ? 128 : 32)));
         @(negedge i_clk_sys);
      end
      $display("state test over");
   endtask : t_state
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_sim
   initial begin
      repeat (16) @(negedge i_clk_sys);
      i_srst = 1'b0;
      @(negedge i_clk_sys);
      t_arith();
      t_lanes();
      t_shift();
      t_move();
      t_state();
      end_sim();
   end
endmodule : test_packed_simd_integer_alu
`default_nettype wire
